// ---- verilog/iesc_top.sv ----
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module iesc_top
    import iesc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IESC_AW-1:0] paddr,
    input wire logic [IESC_DW-1:0] pwdata,
    output logic [IESC_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault events
    input wire logic parity_fault_evt,
    input wire logic system_fault_evt,
    input wire logic initiator_abort_evt,
    input wire logic responder_abort_evt,
    // Unit side
    output logic processor_irq_line,
    output logic [IESC_DW-1:0] irq_enable_bits,
    output logic [IESC_DW-1:0] irq_status_bits
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic iesc_hit(input logic [IESC_AW-1:0] a,
                                      input logic [IESC_AW-1:0] off);
        return a == off;
    endfunction

    logic [IESC_DW-1:0] enable_reg;
    logic [IESC_DW-1:0] status_reg;
    logic [IESC_DW-1:0] status_next;
    logic [IESC_DW-1:0] prdata_reg;
    logic [IESC_DW-1:0] rdata_next;
    logic [IESC_DW-1:0] evt_mask;
    logic [IESC_DW-1:0] w1c_mask;
    logic [IESC_DW-1:0] trig_mask;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic acc_wait;
    logic acc_done;
    logic wr_done;
    logic wr_set;
    logic wr_clr;
    logic wr_stat;
    logic wr_trig;
    logic addr_mapped;

    assign acc_wait = psel & penable & ~pready_reg;
    assign acc_done = psel & penable & pready_reg;
    assign wr_done = acc_done & pwrite;
    assign wr_set = wr_done & iesc_hit(paddr, IESC_OFF_SET_PORT);
    assign wr_clr = wr_done & iesc_hit(paddr, IESC_OFF_CLR_PORT);
    assign wr_stat = wr_done & iesc_hit(paddr, IESC_OFF_STATUS);
    assign wr_trig = wr_done & iesc_hit(paddr, IESC_OFF_SOFT_TRIG);
    assign addr_mapped = iesc_hit(paddr, IESC_OFF_SET_PORT) |
                         iesc_hit(paddr, IESC_OFF_CLR_PORT) |
                         iesc_hit(paddr, IESC_OFF_STATUS) |
                         iesc_hit(paddr, IESC_OFF_SOFT_TRIG);

    // ************************************************************
    // Enable register
    // ************************************************************
    iesc_enable_reg iesc_enable_reg_inst (
        .pclk(pclk),
        .presetn(presetn),
        .set_en(wr_set),
        .clr_en(wr_clr),
        .wdata(pwdata),
        .enable_reg(enable_reg)
    );

    // ************************************************************
    // Status register, event set wins over clear
    // ************************************************************
    always_comb begin
        evt_mask = IESC_ZERO;
        evt_mask[IESC_PARITY_BIT] = parity_fault_evt;
        evt_mask[IESC_SYSTEM_BIT] = system_fault_evt;
        evt_mask[IESC_INIT_ABORT_BIT] = initiator_abort_evt;
        evt_mask[IESC_RESP_ABORT_BIT] = responder_abort_evt;
        trig_mask = wr_trig ? (pwdata & IESC_SOFT_MASK) : IESC_ZERO;
        w1c_mask = wr_stat ? iesc_defined(pwdata) : IESC_ZERO;
        status_next = (status_reg & ~w1c_mask) | evt_mask | trig_mask;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= IESC_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        rdata_next = IESC_ZERO;
        if (iesc_hit(paddr, IESC_OFF_SET_PORT)) begin
            rdata_next = iesc_defined(enable_reg);
        end else if (iesc_hit(paddr, IESC_OFF_CLR_PORT)) begin
            rdata_next = iesc_defined(status_reg & enable_reg);
        end else if (iesc_hit(paddr, IESC_OFF_STATUS)) begin
            rdata_next = iesc_defined(status_reg);
        end
    end

    // ************************************************************
    // APB response, one wait state
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= acc_wait;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= IESC_ZERO;
        end else if (acc_wait && !pwrite) begin
            prdata_reg <= rdata_next;
        end else begin
            prdata_reg <= IESC_ZERO;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= acc_wait & ~addr_mapped;
        end
    end

    // ************************************************************
    // Interrupt line
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & enable_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign processor_irq_line = irq_reg;
    assign irq_enable_bits = enable_reg;
    assign irq_status_bits = status_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic rd_set_done;
    logic rd_clr_done;
    assign rd_set_done = acc_done & ~pwrite & iesc_hit(paddr, IESC_OFF_SET_PORT);
    assign rd_clr_done = acc_done & ~pwrite & iesc_hit(paddr, IESC_OFF_CLR_PORT);

    a_clr_soft_bits: assert property (
        wr_clr |=> ((enable_reg & IESC_SOFT_MASK & $past(pwdata)) == IESC_ZERO))
        else $error("soft enable not cleared");

    a_clr_zero_keep: assert property (
        wr_clr |=> ((enable_reg & ~$past(pwdata)) == ($past(enable_reg) & ~$past(pwdata))))
        else $error("zero write changed an enable");

    a_clr_parity_bit: assert property (
        wr_clr && pwdata[IESC_PARITY_BIT] |=> !enable_reg[IESC_PARITY_BIT])
        else $error("parity enable not cleared");

    a_clr_system_bit: assert property (
        wr_clr && pwdata[IESC_SYSTEM_BIT] |=> !enable_reg[IESC_SYSTEM_BIT])
        else $error("system enable not cleared");

    a_clr_init_abort: assert property (
        wr_clr && pwdata[IESC_INIT_ABORT_BIT] |=> !enable_reg[IESC_INIT_ABORT_BIT])
        else $error("initiator abort enable not cleared");

    a_clr_resp_abort: assert property (
        wr_clr && pwdata[IESC_RESP_ABORT_BIT] |=> !enable_reg[IESC_RESP_ABORT_BIT])
        else $error("responder abort enable not cleared");

    a_view_soft_bits: assert property (
        rd_set_done |-> prdata[IESC_SOFT_MSB:IESC_SOFT_LSB] ==
            $past(enable_reg[IESC_SOFT_MSB:IESC_SOFT_LSB]))
        else $error("soft enable view wrong");

    a_view_fault_bits: assert property (
        rd_set_done |-> prdata[IESC_PARITY_BIT] == $past(enable_reg[IESC_PARITY_BIT])
            && prdata[IESC_SYSTEM_BIT] == $past(enable_reg[IESC_SYSTEM_BIT]))
        else $error("parity or system enable view wrong");

    a_view_abort_bits: assert property (
        rd_set_done |-> prdata[IESC_INIT_ABORT_BIT] == $past(enable_reg[IESC_INIT_ABORT_BIT])
            && prdata[IESC_RESP_ABORT_BIT] == $past(enable_reg[IESC_RESP_ABORT_BIT]))
        else $error("abort enable view wrong");

    a_set_port_write: assert property (
        wr_set |=> (enable_reg == ($past(enable_reg) | ($past(pwdata) & IESC_DEFINED_MASK))))
        else $error("set port write wrong");

    a_irq_line_level: assert property (
        ##1 processor_irq_line == |($past(status_reg) & $past(enable_reg)))
        else $error("interrupt line wrong");

    a_clr_port_read: assert property (
        rd_clr_done |-> prdata == ($past(status_reg) & $past(enable_reg) & IESC_DEFINED_MASK))
        else $error("masked status read wrong");

    a_reserved_zero: assert property (
        ((enable_reg | status_reg | prdata) & ~IESC_DEFINED_MASK) == IESC_ZERO)
        else $error("reserved bit set");

    a_event_beats_clear: assert property (
        wr_stat && parity_fault_evt |=> status_reg[IESC_PARITY_BIT])
        else $error("event lost under clear");

    a_pready_pulse: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready timing wrong");

    // ************************************************************
    // Bus response checks
    // ************************************************************
    a_unmapped_error: assert property (
        acc_wait && !addr_mapped |=> pslverr)
        else $error("unmapped access without error");

    a_mapped_no_error: assert property (
        acc_wait && addr_mapped |=> !pslverr)
        else $error("error on mapped access");

    a_pready_idle_low: assert property (
        !(psel && penable) |=> !pready)
        else $error("pready outside access");

    a_rdata_idle_zero: assert property (
        !pready |-> prdata == IESC_ZERO)
        else $error("read data outside answer");

    a_write_rdata_zero: assert property (
        acc_done && pwrite |-> prdata == IESC_ZERO)
        else $error("read data on write");

    a_trig_read_zero: assert property (
        acc_done && !pwrite && iesc_hit(paddr, IESC_OFF_SOFT_TRIG) |-> prdata == IESC_ZERO)
        else $error("soft trigger read not zero");

    // ************************************************************
    // Register state checks
    // ************************************************************
    a_set_zero_keep: assert property (
        wr_set |=> ((enable_reg & ~$past(pwdata)) == ($past(enable_reg) & ~$past(pwdata))))
        else $error("zero set write changed an enable");

    a_enable_quiet: assert property (
        !wr_set && !wr_clr |=> $stable(enable_reg))
        else $error("enable changed without write");

    a_read_no_change: assert property (
        acc_done && !pwrite |=> $stable(enable_reg))
        else $error("read changed an enable");

    a_parity_evt_set: assert property (
        parity_fault_evt |=> status_reg[IESC_PARITY_BIT])
        else $error("parity event did not set status");

    a_system_evt_set: assert property (
        system_fault_evt |=> status_reg[IESC_SYSTEM_BIT])
        else $error("system event did not set status");

    a_init_evt_set: assert property (
        initiator_abort_evt |=> status_reg[IESC_INIT_ABORT_BIT])
        else $error("initiator abort event did not set status");

    a_resp_evt_set: assert property (
        responder_abort_evt |=> status_reg[IESC_RESP_ABORT_BIT])
        else $error("responder abort event did not set status");

    a_status_w1c_clear: assert property (
        wr_stat |=> (status_reg & $past(w1c_mask & ~evt_mask)) == IESC_ZERO)
        else $error("status write did not clear");

    a_soft_trig_set: assert property (
        wr_trig |=> (status_reg & $past(trig_mask)) == $past(trig_mask))
        else $error("soft trigger did not set status");

    a_status_quiet: assert property (
        !wr_stat && !wr_trig && evt_mask == IESC_ZERO |=> $stable(status_reg))
        else $error("status changed without cause");

endmodule // iesc_top

// ---- shared/iesc_pkg.sv ----
package iesc_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int IESC_AW = 8;
    localparam int IESC_DW = 32;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [IESC_AW-1:0] IESC_OFF_SET_PORT = 8'h00;
    localparam logic [IESC_AW-1:0] IESC_OFF_CLR_PORT = 8'h04;
    localparam logic [IESC_AW-1:0] IESC_OFF_STATUS = 8'h08;
    localparam logic [IESC_AW-1:0] IESC_OFF_SOFT_TRIG = 8'h0c;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int IESC_SOFT_LSB = 24;
    localparam int IESC_SOFT_MSB = 27;
    localparam int IESC_PARITY_BIT = 6;
    localparam int IESC_SYSTEM_BIT = 5;
    localparam int IESC_INIT_ABORT_BIT = 2;
    localparam int IESC_RESP_ABORT_BIT = 1;

    // ************************************************************
    // Masks and reset values
    // ************************************************************
    localparam logic [IESC_DW-1:0] IESC_DEFINED_MASK = 32'h0f000066;
    localparam logic [IESC_DW-1:0] IESC_SOFT_MASK = 32'h0f000000;
    localparam logic [IESC_DW-1:0] IESC_ENABLE_RESET = 32'h00000000;
    localparam logic [IESC_DW-1:0] IESC_STATUS_RESET = 32'h00000000;
    localparam logic [IESC_DW-1:0] IESC_ZERO = 32'h00000000;

    // Keeps only the defined bit positions
    function automatic logic [IESC_DW-1:0] iesc_defined(input logic [IESC_DW-1:0] d);
        return d & IESC_DEFINED_MASK;
    endfunction

endpackage

// ---- verilog/iesc_enable_reg.sv ----
`timescale 1ns/1ps
module iesc_enable_reg
    import iesc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Update strobes
    input wire logic set_en,
    input wire logic clr_en,
    input wire logic [IESC_DW-1:0] wdata,
    // Enable state
    output logic [IESC_DW-1:0] enable_reg
);

    // ************************************************************
    // Internal enable register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= IESC_ENABLE_RESET;
        end else if (set_en) begin
            enable_reg <= enable_reg | iesc_defined(wdata);
        end else if (clr_en) begin
            enable_reg <= enable_reg & ~iesc_defined(wdata);
        end
    end

endmodule // iesc_enable_reg

// ---- dv/test_irq_enable_set_clear.sv ----
`timescale 1ns/1ps
module test_irq_enable_set_clear;
    import iesc_pkg::*;
    // ************************************************************
    // Signals and bench state
    // ************************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, processor_irq_line;
    logic [IESC_AW-1:0] paddr;
    logic [IESC_DW-1:0] pwdata, prdata, en_m, st_m, r, en_bits, st_bits;
    logic [3:0] evt;
    logic [98:0] notes[$];
    logic [98:0] exp_note, got_note;
    int miscompares, n_compared;
    localparam logic [IESC_AW-1:0] OFF_HOLE = 8'h10;
    localparam int EVT_BIT[4] = '{6, 5, 2, 1};

    iesc_top iesc_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .parity_fault_evt(evt[0]), .system_fault_evt(evt[1]),
        .initiator_abort_evt(evt[2]), .responder_abort_evt(evt[3]),
        .processor_irq_line(processor_irq_line), .irq_enable_bits(en_bits),
        .irq_status_bits(st_bits)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ************************************************************
    // Checker and tasks
    // ************************************************************
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && notes.size() > 0) begin
            exp_note = notes.pop_front();
            got_note = {exp_note[98], pslverr, processor_irq_line,
                        exp_note[98] ? prdata : IESC_ZERO, en_bits, st_bits};
            n_compared++;
            if (got_note !== exp_note) begin
                miscompares++;
                $display("CHECK FAILED at %0t: expected %h got %h", $time, exp_note, got_note);
            end
        end
    end

    task automatic results();
        $display("Compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic hole(input logic [IESC_AW-1:0] a);
        return !(a inside {IESC_OFF_SET_PORT, IESC_OFF_CLR_PORT, IESC_OFF_STATUS, IESC_OFF_SOFT_TRIG});
    endfunction

    task automatic apb(input logic w, input logic [IESC_AW-1:0] a, input logic [IESC_DW-1:0] d,
                       input logic [IESC_DW-1:0] e);
        int n;
        notes.push_back({~w, hole(a), |(st_m & en_m), e, en_m, st_m});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            results();
        end
    endtask

    task automatic wr(input logic [IESC_AW-1:0] a, input logic [IESC_DW-1:0] d);
        apb(1'b1, a, d, IESC_ZERO);
        case (a)
            IESC_OFF_SET_PORT: en_m = en_m | (d & IESC_DEFINED_MASK);
            IESC_OFF_CLR_PORT: en_m = en_m & ~d;
            IESC_OFF_STATUS: st_m = st_m & ~d;
            IESC_OFF_SOFT_TRIG: st_m = st_m | (d & IESC_SOFT_MASK);
            default: ;
        endcase
    endtask

    task automatic rd(input logic [IESC_AW-1:0] a);
        case (a)
            IESC_OFF_SET_PORT: apb(1'b0, a, IESC_ZERO, en_m);
            IESC_OFF_CLR_PORT: apb(1'b0, a, IESC_ZERO, st_m & en_m);
            IESC_OFF_STATUS: apb(1'b0, a, IESC_ZERO, st_m);
            default: apb(1'b0, a, IESC_ZERO, IESC_ZERO);
        endcase
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        evt[i] <= 1'b1;
        @(posedge pclk);
        evt[i] <= 1'b0;
        st_m[EVT_BIT[i]] = 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        evt = '0;
        en_m = IESC_ENABLE_RESET;
        st_m = IESC_STATUS_RESET;
        r = $urandom(5563);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(IESC_OFF_SET_PORT);
        rd(IESC_OFF_CLR_PORT);
        for (int i = 0; i < 32; i++) begin
            wr(IESC_OFF_SET_PORT, 32'hffffffff);
            wr(IESC_OFF_CLR_PORT, 32'h1 << i);
            rd(IESC_OFF_SET_PORT);
        end
        wr(IESC_OFF_CLR_PORT, IESC_ZERO);
        wr(IESC_OFF_SET_PORT, IESC_ZERO);
        rd(IESC_OFF_SET_PORT);
        for (int i = 0; i < 24; i++) begin
            r = $urandom();
            wr(r[0] ? IESC_OFF_SET_PORT : IESC_OFF_CLR_PORT, $urandom());
            rd(IESC_OFF_SET_PORT);
        end
        wr(IESC_OFF_SET_PORT, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            rd(IESC_OFF_CLR_PORT);
            wr(IESC_OFF_CLR_PORT, 32'h1 << EVT_BIT[i]);
            rd(IESC_OFF_CLR_PORT);
            wr(IESC_OFF_STATUS, 32'hffffffff);
            rd(IESC_OFF_STATUS);
        end
        wr(IESC_OFF_SET_PORT, 32'hffffffff);
        wr(IESC_OFF_SOFT_TRIG, 32'hffffffff);
        rd(IESC_OFF_CLR_PORT);
        wr(IESC_OFF_CLR_PORT, IESC_SOFT_MASK);
        rd(IESC_OFF_CLR_PORT);
        wr(IESC_OFF_CLR_PORT, 32'hffffffff);
        fork
            wr(IESC_OFF_STATUS, 32'hffffffff);
            begin
                repeat (3) @(posedge pclk);
                evt[0] <= 1'b1;
                @(posedge pclk);
                evt[0] <= 1'b0;
            end
        join
        st_m[EVT_BIT[0]] = 1'b1;
        rd(IESC_OFF_STATUS);
        wr(OFF_HOLE, IESC_ZERO);
        rd(OFF_HOLE);
        rd(IESC_OFF_SET_PORT);
        repeat (5) @(posedge pclk);
        results();
    end
endmodule // test_irq_enable_set_clear
